// ---- hdl/charge_time_unit.v ----
// charge time unit register bank with apb slave, edge flags and current source control
// Functional notes
// - trim code sits in bits 7-2; larger positive codes raise current more.
// - trim code zero gives the nominal current of the selected range.
// - trim is two's complement; all ones is smallest downward step.
// - range select 11 gives one hundred times base current.
// - range 10 gives ten times base, 01 gives base current.
// - range 00 keeps the current source off whatever the trim.
// - reset clears every register; unit disabled and source off.
// - with edge pass enable clear, no edge can set a status flag.
// - with edge order enable set, second edge needs first edge recorded.
`include "charge_time_unit_consts.vh"

module charge_time_unit (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire edge_input_pin_one,
    input wire edge_input_pin_two,
    input wire [1:0] special_event_triggers,
    input wire idle_request,
    output reg irq,
    output reg source_on,
    output reg [2:0] range_onehot,
    output reg [5:0] trim_offset,
    output reg source_ground,
    output reg trigger_out,
    output reg pulse_charge
);
    // =======================================
    // register state
    reg [7:0] unit_control_high;
    reg [7:0] edge_control_low;
    reg [7:0] current_source_control;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;

    wire [3:0] sources;
    wire first_edge;
    wire second_edge;
    wire dec_source_on;
    wire [2:0] dec_range;
    wire [5:0] dec_trim;
    wire setup;
    wire access_wr;
    wire wr_en;
    wire hit_high;
    wire hit_low;
    wire hit_cur;
    wire hit_sts;
    wire hit_msk;
    wire mapped;
    wire unit_enable;
    wire edge_pass_enable;
    wire edge_order_enable;
    wire delay_generation_enable;
    wire source_enable;
    wire set_first;
    wire set_second;
    reg [31:0] next_prdata;
    reg [7:0] next_low;

    assign unit_enable = unit_control_high[`BIT_UNIT_ENABLE];
    assign edge_pass_enable = unit_control_high[`BIT_EDGE_PASS_ENABLE];
    assign edge_order_enable = unit_control_high[`BIT_EDGE_ORDER_ENABLE];
    assign delay_generation_enable = unit_control_high[`BIT_DELAY_GEN_ENABLE];
    assign source_enable = unit_enable && !(unit_control_high[`BIT_STOP_IN_IDLE] && idle_request);

    // source order: 00/01 special event triggers, 10 pin two, 11 pin one
    assign sources = {edge_input_pin_one, edge_input_pin_two, special_event_triggers};

    // =======================================
    // edge detection
    edge_detect u_first (
        .pclk(pclk),
        .presetn(presetn),
        .sources(sources),
        .source_select(edge_control_low[`POS_FIRST_EDGE_SOURCE +: 2]),
        .polarity(edge_control_low[`BIT_FIRST_EDGE_POLARITY]),
        .active_edge(first_edge)
    );

    edge_detect u_second (
        .pclk(pclk),
        .presetn(presetn),
        .sources(sources),
        .source_select(edge_control_low[`POS_SECOND_EDGE_SOURCE +: 2]),
        .polarity(edge_control_low[`BIT_SECOND_EDGE_POLARITY]),
        .active_edge(second_edge)
    );

    // blocked edges never reach the flags; disabled unit ignores edges too
    assign set_first = unit_enable && edge_pass_enable && first_edge;
    assign set_second = unit_enable && edge_pass_enable && second_edge
        && (!edge_order_enable || edge_control_low[`BIT_FIRST_EDGE_SEEN]);

    // =======================================
    // current source decode
    current_source_decode u_decode (
        .pclk(pclk),
        .presetn(presetn),
        .enable(source_enable),
        .range_select(current_source_control[`POS_CURRENT_RANGE_SELECT +: 2]),
        .trim_code(current_source_control[`POS_CURRENT_TRIM_CODE +: 6]),
        .source_on(dec_source_on),
        .range_onehot(dec_range),
        .trim_offset(dec_trim)
    );

    // =======================================
    // apb decode
    assign setup = psel && !penable;
    assign access_wr = psel && penable && pready && pwrite;
    assign wr_en = access_wr && pstrb[0];
    assign hit_high = (paddr == `OFS_UNIT_CONTROL_HIGH);
    assign hit_low = (paddr == `OFS_EDGE_CONTROL_LOW);
    assign hit_cur = (paddr == `OFS_CURRENT_SOURCE_CONTROL);
    assign hit_sts = (paddr == `OFS_IRQ_STATUS);
    assign hit_msk = (paddr == `OFS_IRQ_MASK);
    assign mapped = hit_high || hit_low || hit_cur || hit_sts || hit_msk;

    always @* begin
        next_prdata = 32'h0000_0000;
        if (hit_high) begin
            next_prdata[7:0] = unit_control_high;
        end else if (hit_low) begin
            next_prdata[7:0] = edge_control_low;
        end else if (hit_cur) begin
            next_prdata[7:0] = current_source_control;
        end else if (hit_sts) begin
            next_prdata[1:0] = irq_status;
        end else if (hit_msk) begin
            next_prdata[1:0] = irq_mask;
        end
    end

    // flags: hardware set wins over a software clear in the same cycle
    always @* begin
        next_low = edge_control_low;
        if (wr_en && hit_low) begin
            next_low = pwdata[7:0];
        end
        if (set_first) begin
            next_low[`BIT_FIRST_EDGE_SEEN] = 1'b1;
        end
        if (set_second) begin
            next_low[`BIT_SECOND_EDGE_SEEN] = 1'b1;
        end
    end

    // =======================================
    // apb slave: no wait state, answer in the cycle after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // =======================================
    // registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_control_high <= `RESET_BYTE;
            edge_control_low <= `RESET_BYTE;
            current_source_control <= `RESET_BYTE;
            irq_status <= `RESET_IRQ;
            irq_mask <= `RESET_IRQ;
        end else begin
            edge_control_low <= next_low;
            if (wr_en && hit_high) begin
                unit_control_high <= pwdata[7:0] & `MASK_UNIT_CONTROL_HIGH;
            end
            if (wr_en && hit_cur) begin
                current_source_control <= pwdata[7:0];
            end
            if (wr_en && hit_msk) begin
                irq_mask <= pwdata[1:0];
            end
            // write one to clear; a new event in the same cycle survives
            irq_status <= ((wr_en && hit_sts) ? (irq_status & ~pwdata[1:0]) : irq_status)
                | {set_second, set_first};
        end
    end

    // =======================================
    // registered outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            source_on <= 1'b0;
            range_onehot <= 3'b000;
            trim_offset <= 6'b00_0000;
            source_ground <= 1'b0;
            trigger_out <= 1'b0;
            pulse_charge <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
            source_on <= dec_source_on;
            range_onehot <= dec_range;
            trim_offset <= dec_trim;
            source_ground <= unit_control_high[`BIT_SOURCE_GROUND];
            trigger_out <= unit_enable && unit_control_high[`BIT_TRIGGER_ENABLE]
                && edge_control_low[`BIT_SECOND_EDGE_SEEN];
            // charging runs from first edge set until second edge in delay mode
            pulse_charge <= unit_enable && delay_generation_enable
                && edge_control_low[`BIT_FIRST_EDGE_SEEN] && !edge_control_low[`BIT_SECOND_EDGE_SEEN];
        end
    end
endmodule

// ---- hdl/charge_time_unit_consts.vh ----
// register offsets, field positions and reset values of the charge time unit
`ifndef CHARGE_TIME_UNIT_CONSTS_VH
`define CHARGE_TIME_UNIT_CONSTS_VH

// ========================================
// register byte offsets
`define OFS_UNIT_CONTROL_HIGH 12'h000
`define OFS_EDGE_CONTROL_LOW 12'h004
`define OFS_CURRENT_SOURCE_CONTROL 12'h008
`define OFS_IRQ_STATUS 12'h00C
`define OFS_IRQ_MASK 12'h010

// ========================================
// unit_control_high fields
`define BIT_UNIT_ENABLE 7
`define BIT_STOP_IN_IDLE 5
`define BIT_DELAY_GEN_ENABLE 4
`define BIT_EDGE_PASS_ENABLE 3
`define BIT_EDGE_ORDER_ENABLE 2
`define BIT_SOURCE_GROUND 1
`define BIT_TRIGGER_ENABLE 0
`define MASK_UNIT_CONTROL_HIGH 8'hBF

// ========================================
// edge_control_low fields
`define BIT_SECOND_EDGE_POLARITY 7
`define POS_SECOND_EDGE_SOURCE 5
`define BIT_FIRST_EDGE_POLARITY 4
`define POS_FIRST_EDGE_SOURCE 2
`define BIT_SECOND_EDGE_SEEN 1
`define BIT_FIRST_EDGE_SEEN 0

// ========================================
// current_source_control fields
`define POS_CURRENT_TRIM_CODE 2
`define POS_CURRENT_RANGE_SELECT 0
`define RANGE_OFF 2'b00
`define RANGE_BASE 2'b01
`define RANGE_TIMES_TEN 2'b10
`define RANGE_TIMES_HUNDRED 2'b11

// ========================================
// reset values
`define RESET_BYTE 8'h00
`define RESET_IRQ 2'b00

`endif

// ---- hdl/edge_detect.v ----
// polarity-selectable edge detector for one selected event source
module edge_detect (
    input wire pclk,
    input wire presetn,
    input wire [3:0] sources,
    input wire [1:0] source_select,
    input wire polarity,
    output wire active_edge
);
    reg [3:0] previous;
    wire current;
    wire last;

    assign current = sources[source_select];
    assign last = previous[source_select];

    // =======================================
    // history of every source, so a change of select cannot fake an edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            previous <= 4'b0000;
        end else begin
            previous <= sources;
        end
    end

    // polarity 1 means rising, 0 falling
    assign active_edge = polarity ? (current & ~last) : (~current & last);
endmodule

// ---- hdl/current_source_decode.v ----
// decodes range and trim into analog current source controls
`include "charge_time_unit_consts.vh"
module current_source_decode (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire [1:0] range_select,
    input wire [5:0] trim_code,
    output reg source_on,
    output reg [2:0] range_onehot,
    output reg signed [5:0] trim_offset
);
    // =======================================
    // registered decode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_on <= 1'b0;
            range_onehot <= 3'b000;
            trim_offset <= 6'sb000000;
        end else begin
            source_on <= enable && (range_select != `RANGE_OFF);
            case (range_select)
                `RANGE_BASE: range_onehot <= 3'b001;
                `RANGE_TIMES_TEN: range_onehot <= 3'b010;
                `RANGE_TIMES_HUNDRED: range_onehot <= 3'b100;
                default: range_onehot <= 3'b000;
            endcase
            // two's complement: zero gives nominal, negative codes lower it
            if (range_select == `RANGE_OFF) begin
                trim_offset <= 6'sb000000;
            end else begin
                trim_offset <= $signed(trim_code);
            end
        end
    end
endmodule

// ---- bench/charge_time_unit_sva.sv ----
// port-level assertions for the charge time unit
module charge_time_unit_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire irq,
    input wire source_on,
    input wire [2:0] range_onehot,
    input wire [5:0] trim_offset,
    input wire trigger_out,
    input wire pulse_charge
);
    wire wr_done = psel && penable && pwrite && pready;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================
    // bus handshake
    sequence s_setup;
        psel && !penable && !pready;
    endsequence
    a_setup_answer: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    // ========================================
    // current source, irq, pulse and trigger outputs
    // trim may only move two or three edges after a committed write
    a_trim_cause: assert property ($changed(trim_offset) |-> $past(wr_done, 2) || $past(wr_done, 3))
        else $error("trim moved without write");
    a_off_no_source: assert property (range_onehot == 3'b000 |-> !source_on)
        else $error("source on while off");
    a_off_no_trim: assert property (range_onehot == 3'b000 |-> trim_offset == 6'h00)
        else $error("trim while off");
    a_range_onehot: assert property ($onehot0(range_onehot))
        else $error("range not one-hot");
    a_reset_clear: assert property (disable iff (1'b0) $rose(presetn) |-> !irq && !source_on && !pulse_charge)
        else $error("output set in reset");
    a_pulse_trigger: assert property (pulse_charge |-> !trigger_out)
        else $error("pulse and trigger together");
endmodule

bind charge_time_unit charge_time_unit_sva i_sva (.*);

// ---- bench/charge_time_unit_tb_top.sv ----
// self-checking testbench of the charge time unit register bank
`include "charge_time_unit_consts.vh"
module charge_time_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0] pstrb = 4'hf;
    logic edge_input_pin_one = 0, edge_input_pin_two = 1, idle_request = 0;
    logic [1:0] special_event_triggers = 0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, source_on, source_ground, trigger_out, pulse_charge;
    wire [2:0] range_onehot;
    wire [5:0] trim_offset;
    int n_fail = 0, samples_checked = 0;
    logic [31:0] seed = 32'h0000_4932;
    logic [7:0] m_edge;
    logic [5:0] t;
    logic [1:0] r;
    logic [5:0] tc [4] = '{6'h3f, 6'h00, 6'h1f, 6'h21};

    charge_time_unit i_dut (.*);

    always #4 pclk = ~pclk;

    // ========================================
    // helpers
    task stop_test();
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // request held until the rising edge at which ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            stop_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask

    task pins(input logic a, input logic b);
        @(posedge pclk);
        edge_input_pin_one <= a;
        edge_input_pin_two <= b;
        repeat (3) @(posedge pclk);
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 5; i++)
            rchk(12'(i * 4), 0);
        apb(0, 12'h014, 0);
        chk(rd, 0);
        chk(err, 1);
        apb(1, `OFS_UNIT_CONTROL_HIGH, 8'hff);
        rchk(`OFS_UNIT_CONTROL_HIGH, `MASK_UNIT_CONTROL_HIGH);
        chk(source_ground, 1);
        apb(1, `OFS_UNIT_CONTROL_HIGH, 8'h80);
        for (int i = 0; i < 8; i++) begin
            t = (i < 4) ? tc[i] : 6'(rnd());
            r = 2'(i);
            apb(1, `OFS_CURRENT_SOURCE_CONTROL, {t, r});
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk(source_on, r != 0);
            chk(range_onehot, r ? 3'b001 << (r - 1) : 3'b000);
            chk(trim_offset, r ? t : 6'h00);
            rchk(`OFS_CURRENT_SOURCE_CONTROL, {t, r});
        end
        // stop-in-idle drops the source only while idle is requested
        apb(1, `OFS_UNIT_CONTROL_HIGH, 8'ha0);
        @(posedge pclk);
        idle_request <= 1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(source_on, 0);
        @(posedge pclk);
        idle_request <= 0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(source_on, 1);
        apb(1, `OFS_UNIT_CONTROL_HIGH, 8'h80);
        // first edge rising on pin one, second edge falling on pin two
        m_edge = 8'h5c;
        apb(1, `OFS_EDGE_CONTROL_LOW, m_edge);
        pins(1, 0);
        pins(0, 1);
        rchk(`OFS_EDGE_CONTROL_LOW, m_edge);
        apb(1, `OFS_UNIT_CONTROL_HIGH, 8'h8c);
        pins(0, 0);
        rchk(`OFS_EDGE_CONTROL_LOW, m_edge);
        pins(1, 1);
        m_edge[0] = 1;
        rchk(`OFS_EDGE_CONTROL_LOW, m_edge);
        pins(1, 0);
        m_edge[1] = 1;
        rchk(`OFS_EDGE_CONTROL_LOW, m_edge);
        rchk(`OFS_IRQ_STATUS, 3);
        chk(irq, 0);
        apb(1, `OFS_IRQ_MASK, 3);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(irq, 1);
        apb(1, `OFS_IRQ_STATUS, 3);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(irq, 0);
        rchk(`OFS_IRQ_STATUS, 0);
        apb(1, `OFS_EDGE_CONTROL_LOW, 8'h5c);
        rchk(`OFS_EDGE_CONTROL_LOW, 8'h5c);
        // delay generation: software enables it, then sets the first flag
        apb(1, `OFS_UNIT_CONTROL_HIGH, 8'h91);
        apb(1, `OFS_EDGE_CONTROL_LOW, 8'h5d);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(pulse_charge, 1);
        chk(trigger_out, 0);
        chk(source_ground, 0);
        apb(1, `OFS_EDGE_CONTROL_LOW, 8'h5f);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(pulse_charge, 0);
        chk(trigger_out, 1);
        // special event sources, both rising, no ordering
        apb(1, `OFS_UNIT_CONTROL_HIGH, 8'h88);
        apb(1, `OFS_EDGE_CONTROL_LOW, 8'hb0);
        @(posedge pclk);
        special_event_triggers <= 2'b11;
        repeat (3) @(posedge pclk);
        rchk(`OFS_EDGE_CONTROL_LOW, 8'hb3);
        // reset in mid-run clears every register again
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 5; i++)
            rchk(12'(i * 4), 0);
        chk(source_on, 0);
        stop_test();
    end
endmodule
